// ### src/interval_timer.sv
/*
  down-counting interval timer, done is combinational in its final cycle.
  assumes i_step is a single-cycle strobe or held high, from the same clock.
*/
`timescale 1ns/1ps
module interval_timer (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [23:0] i_value,
  input wire logic i_step,
  output logic o_done
);
  logic [23:0] cnt_reg, cnt_next;
  logic run_reg, run_next;

  // load is not folded in here: callers derive their load from done
  assign o_done = run_reg & ((cnt_reg == 24'h000000) | (i_step & (cnt_reg == 24'h000001)));

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (i_load) begin
      cnt_next = i_value;
      run_next = 1'b1;
    end else if (o_done) begin
      run_next = 1'b0;
    end else if (run_reg & i_step) begin
      cnt_next = cnt_reg - 24'h000001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 24'h000000;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end
endmodule

// ### src/meas_sequencer.sv
/*
  chopper measurement sequencer with avalon-mm register slave.
  assumes comparator and trigger pins are asynchronous; analog front end
  applies o_hysteresis; positive slope only.
*/
`timescale 1ns/1ps
`include "mts_defines.svh"
module meas_sequencer #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_ext_trig,
  input wire logic i_above_level,
  input wire logic i_below_rearm,
  output logic [9:0] o_hysteresis,
  output logic o_sync,
  output logic o_integrating,
  output logic o_chop_inverted,
  output logic o_result_valid,
  output logic o_result_settled
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    if (v < {22'h000000, lo}) return lo;
    if (v > {22'h000000, hi}) return hi;
    return v[9:0];
  endfunction

  // ------------------------------------------------------------
  // input synchronisers and tick
  // ------------------------------------------------------------
  logic [2:0] meta_reg, sync_in_reg;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 3'h0;
      sync_in_reg <= 3'h0;
    end else begin
      meta_reg <= {i_ext_trig, i_above_level, i_below_rearm};
      sync_in_reg <= meta_reg;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  always_comb tick_cnt_next = tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  mts_pkg::cfg_s cfg_reg, cfg_next;
  logic [15:0] avg_reg, avg_next;
  logic [13:0] tcount_reg, tcount_next, tally_reg, tally_next, cyc_reg, cyc_next;
  logic [9:0] tdelay_reg, tdelay_next, afwait_reg, afwait_next, quiet_reg, quiet_next;
  logic [9:0] holdoff_reg, holdoff_next, hyst_reg, hyst_next;
  logic [23:0] aper_reg, aper_next;
  logic [31:0] rdata_reg, rdata_next, wd;
  logic ack_reg, ack_next, wr, start_p, stop_p, trig_p;
  mts_pkg::seq_state_e state_reg, state_next;
  logic chop_reg, chop_next, settled_reg, settled_next;

  assign wd = i_avs_writedata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr = i_avs_write & ack_reg;
  assign start_p = wr && i_avs_address == `OFF_CTRL && wd[`CTRL_START];
  assign stop_p = wr && i_avs_address == `OFF_CTRL && wd[`CTRL_STOP];
  assign trig_p = wr && i_avs_address == `OFF_CTRL && wd[`CTRL_TRIG];

  always_comb begin
    ack_next = (i_avs_read | i_avs_write) & ~ack_reg;
    cfg_next = cfg_reg;
    avg_next = avg_reg;
    tcount_next = tcount_reg;
    tdelay_next = tdelay_reg;
    afwait_next = afwait_reg;
    quiet_next = quiet_reg;
    holdoff_next = holdoff_reg;
    hyst_next = hyst_reg;
    aper_next = aper_reg;
    if (wr) begin
      unique case (i_avs_address)
        `OFF_CTRL: cfg_next = wd[`CTRL_CFG_HI:`CTRL_CFG_LO];
        `OFF_AVG: avg_next = (wd[15:0] == 16'h0000) ? `AVG_RST : wd[15:0];
        `OFF_TCOUNT: begin
          if (wd == 32'h00000000) tcount_next = `TCOUNT_RST;
          else if (wd > {18'h00000, `TCOUNT_MAX}) tcount_next = `TCOUNT_MAX;
          else tcount_next = wd[13:0];
        end
        `OFF_TDELAY: tdelay_next = clamp10(wd, 10'h000, `TIME_MAX);
        `OFF_AFWAIT: afwait_next = clamp10(wd, `AFWAIT_MIN, `AFWAIT_MAX);
        `OFF_QUIET: quiet_next = clamp10(wd, 10'h000, `TIME_MAX);
        `OFF_HOLDOFF: holdoff_next = clamp10(wd, 10'h000, `TIME_MAX);
        `OFF_HYST: hyst_next = clamp10(wd, 10'h000, `TIME_MAX);
        `OFF_APER: aper_next = (wd[23:0] == 24'h000000) ? 24'h000001 : wd[23:0];
        default: ;
      endcase
    end
    rdata_next = 32'h00000000;
    unique case (i_avs_address)
      `OFF_CTRL: rdata_next = {20'h00000, cfg_reg, 4'h0};
      `OFF_STATUS: rdata_next = {2'h0, cyc_reg, 12'h000, settled_reg, chop_reg, state_reg};
      `OFF_AVG: rdata_next = {16'h0000, avg_reg};
      `OFF_TCOUNT: rdata_next = {18'h00000, tcount_reg};
      `OFF_TDELAY: rdata_next = {22'h000000, tdelay_reg};
      `OFF_AFWAIT: rdata_next = {22'h000000, afwait_reg};
      `OFF_QUIET: rdata_next = {22'h000000, quiet_reg};
      `OFF_HOLDOFF: rdata_next = {22'h000000, holdoff_reg};
      `OFF_HYST: rdata_next = {22'h000000, hyst_reg};
      `OFF_APER: rdata_next = {8'h00, aper_reg};
      `OFF_TALLY: rdata_next = {18'h00000, tally_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic [15:0] meas_reg, meas_next, fill_reg, fill_next;
  logic res_reg, res_next, sync_reg, sync_next;
  logic q_fire, hw_fire, af_fire, af_done, dl_done, ap_done;
  logic dl_load, ap_load, af_load, phase_end, meas_end, rep_done, last_cycle;
  logic [9:0] eff_delay;

  // a longer manual delay wins over the settling figure
  assign eff_delay = (cfg_reg.auto_settle && `SETTLE_TICKS > tdelay_reg) ?
                     `SETTLE_TICKS : tdelay_reg;
  assign hw_fire = state_reg == mts_pkg::ST_WAIT && (q_fire || cfg_reg.src == mts_pkg::SRC_IMM);
  assign af_fire = state_reg == mts_pkg::ST_WAIT && cfg_reg.auto_fire && af_done
                   && !hw_fire && !trig_p;
  assign phase_end = state_reg == mts_pkg::ST_PHASE && ap_done;
  assign meas_end = (avg_reg == 16'h0001) || chop_reg;
  assign rep_done = cfg_reg.moving || avg_reg == 16'h0001 || meas_reg == avg_reg - 16'h0001;
  assign last_cycle = !cfg_reg.cont && ({1'b0, cyc_reg} + 15'h0001) >= {1'b0, tcount_reg};

  always_comb begin
    state_next = state_reg;
    chop_next = chop_reg;
    meas_next = meas_reg;
    cyc_next = cyc_reg;
    fill_next = fill_reg;
    settled_next = settled_reg;
    tally_next = tally_reg;
    res_next = 1'b0;
    dl_load = 1'b0;
    ap_load = 1'b0;
    if (cfg_next.auto_fire && !cfg_reg.auto_fire) tally_next = 14'h0000;
    else if (af_fire && tally_reg != 14'h3FFF) tally_next = tally_reg + 14'h0001;
    unique case (state_reg)
      mts_pkg::ST_IDLE: if (start_p) begin
        state_next = mts_pkg::ST_WAIT;
        chop_next = 1'b0;
        meas_next = 16'h0000;
        cyc_next = 14'h0000;
        fill_next = 16'h0000;
      end
      mts_pkg::ST_WAIT: begin
        if (trig_p) begin
          state_next = mts_pkg::ST_PHASE;
          ap_load = 1'b1;
        end else if (hw_fire || af_fire) begin
          state_next = mts_pkg::ST_DELAY;
          dl_load = 1'b1;
        end
      end
      mts_pkg::ST_DELAY: if (dl_done) begin
        state_next = mts_pkg::ST_PHASE;
        ap_load = 1'b1;
      end
      mts_pkg::ST_PHASE: if (ap_done) begin
        if (!meas_end) begin
          chop_next = 1'b1;
          state_next = cfg_reg.trace ? mts_pkg::ST_WAIT : mts_pkg::ST_PHASE;
          ap_load = !cfg_reg.trace;
        end else begin
          chop_next = 1'b0;
          if (rep_done) begin
            res_next = 1'b1;
            meas_next = 16'h0000;
            fill_next = (fill_reg >= avg_reg) ? avg_reg : fill_reg + 16'h0001;
            settled_next = !cfg_reg.moving || fill_reg + 16'h0001 >= avg_reg;
            if (cyc_reg != 14'h3FFF) cyc_next = cyc_reg + 14'h0001;
            state_next = last_cycle ? mts_pkg::ST_IDLE : mts_pkg::ST_WAIT;
          end else begin
            meas_next = meas_reg + 16'h0001;
            state_next = cfg_reg.trace ? mts_pkg::ST_WAIT : mts_pkg::ST_PHASE;
            ap_load = !cfg_reg.trace;
          end
        end
      end
    endcase
    if (stop_p) state_next = mts_pkg::ST_IDLE;
    // drops on the same edge that leaves the phase
    sync_next = cfg_reg.sync_en && state_next == mts_pkg::ST_PHASE;
  end
  assign af_load = state_next == mts_pkg::ST_WAIT && state_reg != mts_pkg::ST_WAIT;

  interval_timer u_delay (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_load(dl_load),
    .i_value({14'h0000, eff_delay}), .i_step(tick), .o_done(dl_done));
  interval_timer u_aper (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_load(ap_load),
    .i_value(aper_reg), .i_step(1'b1), .o_done(ap_done));
  interval_timer u_afire (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_load(af_load),
    .i_value({14'h0000, afwait_reg}), .i_step(tick), .o_done(af_done));
  trig_qualifier u_qual (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_src(cfg_reg.src),
    .i_listen(state_reg == mts_pkg::ST_WAIT), .i_tick(tick), .i_ext(sync_in_reg[2]),
    .i_above(sync_in_reg[1]), .i_below(sync_in_reg[0]), .i_quiet(quiet_reg),
    .i_holdoff(holdoff_reg), .o_fire(q_fire));

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg <= 32'h00000000;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      cfg_reg <= '0;
      avg_reg <= `AVG_RST;
      tcount_reg <= `TCOUNT_RST;
      tdelay_reg <= `TDELAY_RST;
      afwait_reg <= `AFWAIT_RST;
      quiet_reg <= 10'h000;
      holdoff_reg <= 10'h000;
      hyst_reg <= 10'h000;
      aper_reg <= `APER_RST;
      state_reg <= mts_pkg::ST_IDLE;
      chop_reg <= 1'b0;
      meas_reg <= 16'h0000;
      cyc_reg <= 14'h0000;
      fill_reg <= 16'h0000;
      settled_reg <= 1'b0;
      tally_reg <= 14'h0000;
      res_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      avg_reg <= avg_next;
      tcount_reg <= tcount_next;
      tdelay_reg <= tdelay_next;
      afwait_reg <= afwait_next;
      quiet_reg <= quiet_next;
      holdoff_reg <= holdoff_next;
      hyst_reg <= hyst_next;
      aper_reg <= aper_next;
      state_reg <= state_next;
      chop_reg <= chop_next;
      meas_reg <= meas_next;
      cyc_reg <= cyc_next;
      fill_reg <= fill_next;
      settled_reg <= settled_next;
      tally_reg <= tally_next;
      res_reg <= res_next;
      sync_reg <= sync_next;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_hysteresis = hyst_reg;
  assign o_sync = sync_reg;
  assign o_integrating = state_reg == mts_pkg::ST_PHASE;
  assign o_chop_inverted = chop_reg;
  assign o_result_valid = res_reg;
  assign o_result_settled = settled_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_inverted_end;
    phase_end && chop_reg;
  endsequence
  a_sync_outside_low: assert property (state_reg inside {mts_pkg::ST_IDLE,
    mts_pkg::ST_WAIT, mts_pkg::ST_DELAY} |-> !o_sync) else $error("sync high outside phase");
  a_sync_blocks_bus: assert property (cfg_reg.sync_en && $past(state_reg) ==
    mts_pkg::ST_PHASE && state_reg == mts_pkg::ST_PHASE |-> o_sync) else $error("sync low");
  a_two_phase_meas: assert property (res_next && avg_reg != 16'h0001 |-> chop_reg)
    else $error("result before inverted phase");
  a_repeat_count: assert property (s_inverted_end ##0 (!cfg_reg.moving &&
    meas_reg == avg_reg - 16'h0001) |=> o_result_valid) else $error("repeat result missing");
  a_moving_result: assert property (s_inverted_end ##0 cfg_reg.moving |=> o_result_valid)
    else $error("moving result missing");
  a_idle_at_count: assert property (res_next && last_cycle && !stop_p |=>
    state_reg == mts_pkg::ST_IDLE) else $error("no idle after trigger count");
  a_trace_retrigger: assert property (phase_end && !chop_reg && avg_reg != 16'h0001 &&
    cfg_reg.trace && !stop_p |=> state_reg == mts_pkg::ST_WAIT) else $error("trace no wait");
  a_avg_one_result: assert property (phase_end && avg_reg == 16'h0001 |=>
    o_result_valid && o_result_settled) else $error("average one result wrong");
  a_auto_fire_gate: assert property (!cfg_reg.auto_fire |-> !af_fire)
    else $error("auto fire while disabled");
  a_tally_step: assert property (af_fire && tally_reg != 14'h3FFF &&
    !(cfg_next.auto_fire && !cfg_reg.auto_fire) |=> tally_reg == $past(tally_reg) + 14'h0001)
    else $error("tally not counted");
  a_delay_first: assert property (hw_fire && !trig_p && !stop_p |=>
    state_reg == mts_pkg::ST_DELAY) else $error("trigger skipped delay");
endmodule

// ### src/mts_defines.svh
/*
  register map, field positions, reset values and time bases of the sequencer.
  assumes a 40 MHz measurement clock.
*/
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_AVG 8'h08
`define OFF_TCOUNT 8'h0C
`define OFF_TDELAY 8'h10
`define OFF_AFWAIT 8'h14
`define OFF_QUIET 8'h18
`define OFF_HOLDOFF 8'h1C
`define OFF_HYST 8'h20
`define OFF_APER 8'h24
`define OFF_TALLY 8'h28
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_TRIG 2
`define CTRL_CFG_LO 4
`define CTRL_CFG_HI 11
// ------------------------------------------------------------
// reset values and ranges (times in 10 ms ticks, aperture in clocks, hysteresis in 0.01 dB)
// ------------------------------------------------------------
`define AVG_RST 16'h0001
`define TCOUNT_RST 14'h0001
`define TCOUNT_MAX 14'h2000
`define TDELAY_RST 10'h000
`define AFWAIT_MIN 10'h00A
`define AFWAIT_MAX 10'h1F4
`define AFWAIT_RST 10'h01E
`define TIME_MAX 10'h3E8
`define APER_RST 24'h000190
`define SETTLE_TICKS 10'h001
// ------------------------------------------------------------
// time base
// ------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define TICK_NS 10000000
`endif

// ### src/mts_pkg.sv
/*
  types shared by the sequencer and its trigger qualifier.
  assumes nothing beyond the defines header.
*/
package mts_pkg;
  typedef enum logic [1:0] {SRC_IMM, SRC_INT, SRC_EXT, SRC_HOLD} trig_src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_PHASE} seq_state_e;
  typedef struct packed {
    trig_src_e src;
    logic auto_settle;
    logic auto_fire;
    logic sync_en;
    logic moving;
    logic trace;
    logic cont;
  } cfg_s;
endpackage

// ### src/trig_qualifier.sv
/*
  trigger qualifier: dropout arming, hysteresis re-arm, edge detect, hold-off.
  assumes all inputs are already synchronised to i_mclk.
*/
`timescale 1ns/1ps
module trig_qualifier (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire mts_pkg::trig_src_e i_src,
  input wire logic i_listen,
  input wire logic i_tick,
  input wire logic i_ext,
  input wire logic i_above,
  input wire logic i_below,
  input wire logic [9:0] i_quiet,
  input wire logic [9:0] i_holdoff,
  output logic o_fire
);
  logic ext_prev_reg, armed_reg, armed_next, fire_reg, cand;
  logic [9:0] quiet_cnt_reg, quiet_cnt_next, hold_cnt_reg, hold_cnt_next;

  always_comb begin
    cand = 1'b0;
    if (i_listen && hold_cnt_reg == 10'h000) begin
      if (i_src == mts_pkg::SRC_INT) cand = armed_reg & i_above;
      else if (i_src == mts_pkg::SRC_EXT) cand = i_ext & ~ext_prev_reg;
    end
    armed_next = armed_reg;
    quiet_cnt_next = 10'h000;
    if (cand) begin
      armed_next = 1'b0;
    end else if (i_below) begin
      // count restarts whenever the threshold is crossed again
      if (quiet_cnt_reg >= i_quiet) armed_next = 1'b1;
      else quiet_cnt_next = quiet_cnt_reg + {9'h000, i_tick};
    end
    hold_cnt_next = hold_cnt_reg;
    if (cand) hold_cnt_next = i_holdoff;
    else if (i_tick && hold_cnt_reg != 10'h000) hold_cnt_next = hold_cnt_reg - 10'h001;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
      fire_reg <= 1'b0;
      quiet_cnt_reg <= 10'h000;
      hold_cnt_reg <= 10'h000;
    end else begin
      ext_prev_reg <= i_ext;
      armed_reg <= armed_next;
      fire_reg <= cand;
      quiet_cnt_reg <= quiet_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  assign o_fire = fire_reg;

  a_holdoff_blocks: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    cand && i_holdoff != 10'h000 |=> !cand [*8])
    else $error("trigger accepted inside hold-off");
  a_quiet_arms: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(armed_reg) |-> $past(quiet_cnt_reg) >= $past(i_quiet) && $past(i_below))
    else $error("armed before dropout time elapsed");
endmodule

// ### tb/test_meas_sequencer.sv
/*
  self-checking bench of the measurement sequencer and its trigger bus.
  assumes TICK_CYCLES of 4, so one 10 ms tick lasts four clocks.
*/
`timescale 1ns/1ps
`include "mts_defines.svh"
module test_meas_sequencer;
  logic i_mclk, i_resetn, rd, wr, fire, pwr, chop_q;
  logic [7:0] addr;
  logic [31:0] wd, rdata, seed, aper;
  logic waitreq, sync, integ, chop, rvalid, settled, ext, above, below;
  logic [9:0] hyst;
  logic [31:0] rq[$];
  logic sq[$];
  int err_total, checks_done, n_int, n_sync, n_chop, n_res, base, l, lat0;
  int td[4] = '{0, 2, 0, 2};
  int ex[4] = '{0, 7, 3, 7};
  mts_pkg::cfg_s cfg;
  meas_sequencer #(.TICK_CYCLES(4)) u_dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_ext_trig(ext), .i_above_level(above),
    .i_below_rearm(below), .o_hysteresis(hyst), .o_sync(sync), .o_integrating(integ),
    .o_chop_inverted(chop), .o_result_valid(rvalid), .o_result_settled(settled));
  trig_bus_model u_bus (.i_mclk(i_mclk), .i_fire(fire), .i_power_hi(pwr),
    .o_ext_trig(ext), .o_above_level(above), .o_below_rearm(below));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", w, e, g);
      err_total++;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // no fixed latency assumed: wait for waitrequest low, bench limit only
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    wd <= d;
    wr <= we;
    rd <= !we;
    do begin
      @(posedge i_mclk);
    end while (waitreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdx(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task go(input logic [3:0] op);
    bus(1'b1, `OFF_CTRL, {20'h0, cfg, op});
  endtask
  task lat();
    l = 0;
    while (integ !== 1'b1 && l < 2000) begin
      @(posedge i_mclk);
      l++;
    end
  endtask
  task wres(input int n);
    int k;
    k = 0;
    while (n_res < n && k < 3000) begin
      @(posedge i_mclk);
      k++;
    end
    chk("result count", n, n_res);
  endtask
  task pulse();
    fire <= 1'b1;
    @(posedge i_mclk);
    fire <= 1'b0;
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // monitor: oldest note against each answer
  // ------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (integ === 1'b1) n_int++;
    if (sync === 1'b1) n_sync++;
    if (chop === 1'b1 && chop_q !== 1'b1) n_chop++;
    chop_q = chop;
    if (rd && waitreq === 1'b0) chk("readdata", rq.pop_front(), rdata);
    if (rvalid === 1'b1) begin
      n_res++;
      chk("settled", {31'h0, sq.pop_front()}, {31'h0, settled});
    end
  end
  initial begin
    wt(60000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    i_resetn = 1'b0;
    {rd, wr, fire, pwr, addr, wd, cfg} = '0;
    pwr = 1'b1;
    seed = 32'hF120;
    wt(4);
    i_resetn <= 1'b1;
    rdx(`OFF_AVG, `AVG_RST);
    rdx(`OFF_TCOUNT, `TCOUNT_RST);
    rdx(`OFF_TDELAY, `TDELAY_RST);
    rdx(`OFF_AFWAIT, `AFWAIT_RST);
    rdx(`OFF_HOLDOFF, 32'h0);
    bus(1'b1, 8'h2C, rnd());
    rdx(8'h2C, 32'h0);
    bus(1'b1, `OFF_TCOUNT, 32'h3FFF);
    rdx(`OFF_TCOUNT, `TCOUNT_MAX);
    bus(1'b1, `OFF_AFWAIT, 32'h1);
    rdx(`OFF_AFWAIT, `AFWAIT_MIN);
    bus(1'b1, `OFF_HYST, `TIME_MAX);
    wt(2);
    chk("hysteresis", `TIME_MAX, hyst);
    $display("test registers done");
    aper = 32'h2 + (rnd() & 32'h3);
    bus(1'b1, `OFF_APER, aper);
    bus(1'b1, `OFF_TCOUNT, 32'h1);
    cfg.sync_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `OFF_TDELAY, td[i]);
      cfg.auto_settle = (i > 1);
      sq.push_back(1'b1);
      base = n_int;
      go(4'h1);
      lat();
      if (i == 0) lat0 = l;
      chk("delay", 1, l + 3 >= lat0 + ex[i] && l <= lat0 + ex[i]);
      wres(n_res + 1);
      wt(20);
      chk("single aperture", aper, n_int - base);
    end
    $display("test delay done");
    bus(1'b1, `OFF_TDELAY, 32'h0);
    bus(1'b1, `OFF_AVG, 32'h4);
    cfg.auto_settle = 1'b0;
    cfg.cont = 1'b1;
    sq.push_back(1'b1);
    base = n_int;
    n_chop = 0;
    go(4'h1);
    wres(n_res + 1);
    chk("repeat phases", aper * 8, n_int - base);
    chk("inverted phases", 4, n_chop);
    go(4'h2);
    wt(10);
    base = n_int;
    wt(40);
    chk("stopped", 0, n_int - base);
    $display("test repeating done");
    bus(1'b1, `OFF_AVG, 32'h2);
    bus(1'b1, `OFF_TCOUNT, 32'h3);
    cfg.cont = 1'b0;
    cfg.moving = 1'b1;
    sq.push_back(1'b0);
    sq.push_back(1'b1);
    sq.push_back(1'b1);
    base = n_int;
    go(4'h1);
    wres(n_res + 3);
    wt(40);
    chk("moving phases", aper * 6, n_int - base);
    $display("test moving done");
    bus(1'b1, `OFF_TCOUNT, 32'h1);
    bus(1'b1, `OFF_HOLDOFF, 32'h14);
    cfg.trace = 1'b1;
    cfg.src = mts_pkg::SRC_EXT;
    sq.push_back(1'b0);
    base = n_int;
    go(4'h1);
    wt(20);
    chk("no trigger", 0, n_int - base);
    pulse();
    wt(30);
    chk("trace phase", aper, n_int - base);
    pulse();
    wt(20);
    chk("hold-off", aper, n_int - base);
    wt(60);
    pulse();
    wres(n_res + 1);
    chk("trace pair", aper * 2, n_int - base);
    $display("test trace done");
    bus(1'b1, `OFF_HOLDOFF, 32'h0);
    bus(1'b1, `OFF_AVG, 32'h1);
    cfg.trace = 1'b0;
    cfg.moving = 1'b0;
    cfg.src = mts_pkg::SRC_HOLD;
    cfg.auto_fire = 1'b1;
    sq.push_back(1'b1);
    go(4'h1);
    lat();
    chk("auto fire", 1, l >= lat0 + 35 && l <= lat0 + 41);
    wres(n_res + 1);
    rdx(`OFF_TALLY, 32'h1);
    $display("test auto fire done");
    cfg.auto_fire = 1'b0;
    cfg.src = mts_pkg::SRC_INT;
    bus(1'b1, `OFF_QUIET, 32'h2);
    base = n_int;
    go(4'h1);
    wt(30);
    chk("no dropout", 0, n_int - base);
    pwr <= 1'b0;
    wt(20);
    pwr <= 1'b1;
    sq.push_back(1'b1);
    wres(n_res + 1);
    wt(10);
    chk("sync cycles", n_int, n_sync);
    $display("test internal done");
    bus(1'b1, `OFF_TDELAY, 32'h2);
    cfg.src = mts_pkg::SRC_HOLD;
    base = n_int;
    go(4'h1);
    wt(20);
    chk("hold waits", 0, n_int - base);
    sq.push_back(1'b1);
    go(4'h4);
    lat();
    chk("sw trigger", 1, l <= 1);
    wres(n_res + 1);
    rdx(`OFF_STATUS, 32'h00010008);
    $display("test software trigger done");
    tally_and_finish();
  end
endmodule

// ### tb/trig_bus_model.sv
/*
  trigger bus and level comparator model on the far side of the sequencer.
  assumes the bench strobes i_fire for one clock and sets i_power_hi on an edge.
*/
`timescale 1ns/1ps
module trig_bus_model (
  input wire logic i_mclk,
  input wire logic i_fire,
  input wire logic i_power_hi,
  output logic o_ext_trig,
  output logic o_above_level,
  output logic o_below_rearm
);
  logic [1:0] hold_reg = 2'h0;
  // pulse outlasts the two-stage synchroniser
  always @(posedge i_mclk) begin
    if (i_fire) hold_reg <= 2'h3;
    else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
  end
  assign o_ext_trig = (hold_reg != 2'h0);
  // no hysteresis gap: exactly one comparator reports at any time
  assign o_above_level = i_power_hi;
  assign o_below_rearm = !i_power_hi;
endmodule
